// ===== sgac_cfg.svh
// Constants for the spectral gain and auto-zero configuration bank
`ifndef SGAC_CFG_SVH
`define SGAC_CFG_SVH
// ==========================================
// Register indexes (byte address is index times four)
`define SGAC_IDX_AUX      10'h090
`define SGAC_IDX_REV      10'h091
`define SGAC_IDX_PART     10'h092
`define SGAC_IDX_CTRL     10'h0b1
`define SGAC_IDX_CEIL     10'h0cf
`define SGAC_IDX_AZ       10'h0d6
// ==========================================
// Field positions
`define SGAC_TRIG_HI      7
`define SGAC_TRIG_LO      6
`define SGAC_FLICKER_AUTO_GAIN_EN_BIT   3
`define SGAC_SPECTRAL_AUTO_GAIN_EN_BIT   2
`define SGAC_FD_CEIL_HI   7
`define SGAC_FD_CEIL_LO   4
`define SGAC_SP_CEIL_HI   3
`define SGAC_SP_CEIL_LO   0
// ==========================================
// Reset values and codes
`define SGAC_AZ_RST       8'hff
`define SGAC_AZ_NEVER     8'h00
`define SGAC_AZ_ONCE      8'hff
`define SGAC_CEIL_RST     4'h9
`define SGAC_CEIL_MAX     4'ha
`define SGAC_TRIG_RST     2'h2
`define SGAC_FLICKER_AUTO_GAIN_EN_RST   1'b1
`define SGAC_SPECTRAL_AUTO_GAIN_EN_RST   1'b0
// ==========================================
// Timing
`define SGAC_AZ_TIME_US   15000
`define SGAC_CLK_MHZ      125
`define SGAC_AZ_CYCLES    (`SGAC_AZ_TIME_US * `SGAC_CLK_MHZ)
`endif

// ===== sgac_pkg.sv
// Types shared by the spectral gain and auto-zero configuration bank
package sgac_pkg;
   // ==========================================
   // Gain ceiling and enable group to the gain engines
   typedef struct packed {
      logic [3:0] fd_ceil;   // Flicker gain ceiling code
      logic [3:0] sp_ceil;   // Spectral gain ceiling code
      logic       flicker_auto_gain_en;    // Flicker auto gain enable
      logic       spectral_auto_gain_en;    // Spectral auto gain enable
   } sgac_gain_cfg_t;

   // ==========================================
   // Auto-zero timer state
   typedef struct packed {
      logic [23:0] cnt;      // Cycles left in operation
      logic        busy;     // Operation in progress
   } sgac_tmr_t;

   // ==========================================
   // Register bank state
   typedef struct packed {
      logic [7:0]     az_interval;  // Auto-zero interval
      sgac_gain_cfg_t gain;         // Ceilings and enables
      logic [1:0]     fifo_trig;    // FIFO trigger code
      logic [7:0]     az_cnt;       // Cycles since last auto-zero
      logic           first_done;   // A cycle has started
      logic           az_pulse;     // Auto-zero start
      logic           az_adc5;      // Converter 5 included
      logic           abort;        // Flicker abort pulse
      logic           fifo_irq;     // FIFO level reached
      logic [24:0]    drop_thr;     // Gain drop threshold
      logic           ack;          // Access phase answered
      logic           slverr;       // Unmapped address
      logic [7:0]     rdata;        // Read data byte
   } sgac_state_t;
endpackage

// ===== sgac_az_timer.sv
// Auto-zero duration timer
`timescale 1ns/100ps
`include "sgac_cfg.svh"
module sgac_az_timer #(
   parameter int CYCLES = `SGAC_AZ_CYCLES  // Length of one operation
) (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   // Control
   input  wire logic i_start,
   // Status
   output logic      o_busy,
   output logic      o_done
);
   // ==========================================
   // State
   sgac_pkg::sgac_tmr_t st_reg;   // Current state
   sgac_pkg::sgac_tmr_t st_next;  // Next state
   logic                done_next;
   logic                done_reg;

   // Start is ignored while busy; a restart would
   // stretch the offset recalibration unboundedly
   always_comb begin
      st_next   = st_reg;
      done_next = 1'b0;
      if (st_reg.busy) begin
         if (st_reg.cnt == 24'h00_0001) begin
            st_next.busy = 1'b0;
            done_next    = 1'b1;
         end
         st_next.cnt = st_reg.cnt - 24'h00_0001;
      end else if (i_start) begin
         st_next.busy = 1'b1;
         st_next.cnt  = 24'(CYCLES);
      end
   end

   // Register the state
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_reg   <= '0;
         done_reg <= 1'b0;
      end else begin
         st_reg   <= st_next;
         done_reg <= done_next;
      end
   end

   assign o_busy = st_reg.busy;
   assign o_done = done_reg;
endmodule // sgac_az_timer

// ===== sgac_regs.sv
// Spectral gain and auto-zero configuration register bank with APB slave
//
// Overview of operation
// RULE1: Interval: 0 never, n every n-th, 255 once
// RULE2: Auto-zero lasts about 15 ms
// RULE3: Flicker enabled adds converter 5 to auto-zero
// RULE4: Converter 5 auto-zero aborts running flicker measurement
// RULE5: Flicker ceiling bits 7:4, 0..10, default 9
// RULE6: Spectral ceiling bits 3:0, 0..10, default 9
// RULE7: FIFO trigger bits 7:6 gives 1,4,8,16
// RULE8: Bit 3 enables flicker auto gain, default set
// RULE9: Bit 2 enables spectral auto gain, default clear
// RULE10: Identification fields read only, writes ignored
// RULE11: Gain code 0 is half, doubles per step
// RULE12: Gain drops above 50 to 87.5 percent
// RULE13: Reserved bits read zero, writes ignored
//
// Our own choice: the APB slave port.
`timescale 1ns/100ps
`include "sgac_cfg.svh"
module sgac_regs #(
   parameter int       AZ_CYCLES = `SGAC_AZ_CYCLES, // Auto-zero length
   parameter bit [5:0] PART_CODE = 6'h2a,  // Arbitrary value
   parameter bit [2:0] REV_CODE  = 3'h5,   // Arbitrary value
   parameter bit [3:0] AUX_CODE  = 4'ha    // Arbitrary value
) (
   // Clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_rst_n,
   // APB slave
   input  wire logic                  i_psel,
   input  wire logic                  i_penable,
   input  wire logic                  i_pwrite,
   input  wire logic [11:0]           i_paddr,
   input  wire logic [31:0]           i_pwdata,
   output logic      [31:0]           o_prdata,
   output logic                       o_pready,
   output logic                       o_pslverr,
   // Measurement engine status
   input  wire logic                  i_cycle_start,
   input  wire logic                  i_flicker_detect_en,
   input  wire logic                  i_flicker_running,
   input  wire logic [5:0]            i_fifo_count,
   input  wire logic [1:0]            i_gain_drop_level,
   input  wire logic [24:0]           i_full_scale,
   // Auto-zero control
   output logic                       o_autozero_start,
   output logic                       o_autozero_busy,
   output logic                       o_autozero_adc5,
   output logic                       o_flicker_abort,
   // Gain control
   output sgac_pkg::sgac_gain_cfg_t   o_gain_cfg,
   output logic      [10:0]           o_spectral_gain_max,
   output logic      [10:0]           o_flicker_gain_max,
   output logic      [24:0]           o_gain_drop_threshold,
   // FIFO
   output logic      [4:0]            o_fifo_level_trigger,
   output logic                       o_fifo_irq
);
   // ==========================================
   // State and decode
   sgac_pkg::sgac_state_t st_reg;    // Current state
   sgac_pkg::sgac_state_t st_next;   // Next state
   logic [9:0]            idx;       // Word index
   logic                  acc;       // Access phase
   logic                  wr_en;     // Write commits
   logic                  mapped;    // Known address
   logic [7:0]            rd_byte;   // Selected read byte
   logic                  az_fire;   // Interval reached
   logic                  tmr_busy;  // Timer running
   logic [27:0]           thr_prod;  // Threshold product

   assign idx    = i_paddr[11:2];
   assign acc    = i_psel && i_penable;
   // One wait state: the write lands on the edge pready is seen
   assign wr_en  = acc && st_reg.ack && i_pwrite && !st_reg.slverr;

   // ==========================================
   // Read mux
   always_comb begin
      mapped  = 1'b1;
      rd_byte = 8'h00;
      case (idx)
         `SGAC_IDX_AUX:  rd_byte = {4'h0, AUX_CODE};     // RULE10 RULE13
         `SGAC_IDX_REV:  rd_byte = {5'h00, REV_CODE};    // RULE10 RULE13
         `SGAC_IDX_PART: rd_byte = {PART_CODE, 2'h0};    // RULE10 RULE13
         // Control: trigger, two enables, reserved zero
         `SGAC_IDX_CTRL: rd_byte = {st_reg.fifo_trig, 2'h0,
                                    st_reg.gain.flicker_auto_gain_en,
                                    st_reg.gain.spectral_auto_gain_en, 2'h0}; // RULE13
         `SGAC_IDX_CEIL: rd_byte = {st_reg.gain.fd_ceil,
                                    st_reg.gain.sp_ceil};
         `SGAC_IDX_AZ:   rd_byte = st_reg.az_interval;
         default:        mapped  = 1'b0;
      endcase
   end

   // ==========================================
   // Gain drop threshold: full scale times (4+code)/8
   assign thr_prod = 28'(i_full_scale) * 28'({1'b1, i_gain_drop_level});

   // ==========================================
   // Next state
   always_comb begin
      st_next          = st_reg;
      st_next.az_pulse = 1'b0;
      st_next.abort    = 1'b0;
      az_fire          = 1'b0;

      // Bus answer: ack rises one cycle into access
      st_next.ack = acc && !st_reg.ack;
      if (acc && !st_reg.ack) begin
         st_next.rdata  = i_pwrite ? 8'h00 : rd_byte;
         st_next.slverr = !mapped;
      end

      // Auto-zero interval scheduling
      if (i_cycle_start) begin
         st_next.first_done = 1'b1;
         case (st_reg.az_interval)
            `SGAC_AZ_NEVER: az_fire = 1'b0;                  // RULE1
            `SGAC_AZ_ONCE:  az_fire = !st_reg.first_done;    // RULE1
            default: begin
               // Fires on the first cycle, then every n-th
               az_fire = (st_reg.az_cnt == 8'h00);           // RULE1
               if (st_reg.az_cnt + 8'h01 >= st_reg.az_interval) begin
                  st_next.az_cnt = 8'h00;
               end else begin
                  st_next.az_cnt = st_reg.az_cnt + 8'h01;
               end
            end
         endcase
      end

      // Skip a due auto-zero while one still runs
      if (az_fire && !tmr_busy) begin
         st_next.az_pulse = 1'b1;
         st_next.az_adc5  = i_flicker_detect_en;                  // RULE3
         st_next.abort    = i_flicker_detect_en && i_flicker_running; // RULE4
      end

      // FIFO level compare
      st_next.fifo_irq = ({1'b0, o_fifo_level_trigger} <= i_fifo_count); // RULE7

      st_next.drop_thr = thr_prod[27:3];                          // RULE12

      // Register writes; identification writes fall through
      if (wr_en) begin
         case (idx)
            `SGAC_IDX_CTRL: begin
               st_next.fifo_trig =
                  i_pwdata[`SGAC_TRIG_HI:`SGAC_TRIG_LO];         // RULE7
               st_next.gain.flicker_auto_gain_en = i_pwdata[`SGAC_FLICKER_AUTO_GAIN_EN_BIT];  // RULE8
               st_next.gain.spectral_auto_gain_en = i_pwdata[`SGAC_SPECTRAL_AUTO_GAIN_EN_BIT];  // RULE9
            end
            `SGAC_IDX_CEIL: begin
               // Codes above the top gain are held at the top
               st_next.gain.fd_ceil =
                  (i_pwdata[`SGAC_FD_CEIL_HI:`SGAC_FD_CEIL_LO] > `SGAC_CEIL_MAX)
                  ? `SGAC_CEIL_MAX
                  : i_pwdata[`SGAC_FD_CEIL_HI:`SGAC_FD_CEIL_LO]; // RULE5
               st_next.gain.sp_ceil =
                  (i_pwdata[`SGAC_SP_CEIL_HI:`SGAC_SP_CEIL_LO] > `SGAC_CEIL_MAX)
                  ? `SGAC_CEIL_MAX
                  : i_pwdata[`SGAC_SP_CEIL_HI:`SGAC_SP_CEIL_LO]; // RULE6
            end
            `SGAC_IDX_AZ: begin
               // New interval restarts the cycle count
               st_next.az_interval = i_pwdata[7:0];              // RULE1
               st_next.az_cnt      = 8'h00;
            end
            default: st_next.rdata = st_next.rdata;              // RULE10
         endcase
      end
   end

   // ==========================================
   // State register
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_reg              <= '0;
         st_reg.az_interval  <= `SGAC_AZ_RST;
         st_reg.gain.fd_ceil <= `SGAC_CEIL_RST;   // RULE5
         st_reg.gain.sp_ceil <= `SGAC_CEIL_RST;   // RULE6
         st_reg.gain.flicker_auto_gain_en  <= `SGAC_FLICKER_AUTO_GAIN_EN_RST; // RULE8
         st_reg.gain.spectral_auto_gain_en  <= `SGAC_SPECTRAL_AUTO_GAIN_EN_RST; // RULE9
         st_reg.fifo_trig    <= `SGAC_TRIG_RST;   // RULE7
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================
   // Auto-zero duration timer
   sgac_az_timer #(
      .CYCLES (AZ_CYCLES)
   ) u_az_timer (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_start (st_reg.az_pulse),   // RULE2
      .o_busy  (tmr_busy),
      .o_done  ()
   );

   // ==========================================
   // Outputs
   assign o_pready              = acc && st_reg.ack;
   assign o_pslverr             = o_pready && st_reg.slverr;
   assign o_prdata              = {24'h00_0000, st_reg.rdata};
   assign o_autozero_start      = st_reg.az_pulse;
   assign o_autozero_busy       = tmr_busy;
   assign o_autozero_adc5       = st_reg.az_adc5 && tmr_busy;   // RULE3
   assign o_flicker_abort       = st_reg.abort;
   assign o_gain_cfg            = st_reg.gain;
   // Half-x units: code 0 is 0.5x, each step doubles
   assign o_spectral_gain_max   = 11'h001 << st_reg.gain.sp_ceil; // RULE11
   assign o_flicker_gain_max    = 11'h001 << st_reg.gain.fd_ceil; // RULE11
   assign o_gain_drop_threshold = st_reg.drop_thr;
   assign o_fifo_irq            = st_reg.fifo_irq;

   // FIFO trigger code to entry count
   always_comb begin
      case (st_reg.fifo_trig)
         2'h0:    o_fifo_level_trigger = 5'h01;   // RULE7
         2'h1:    o_fifo_level_trigger = 5'h04;
         2'h2:    o_fifo_level_trigger = 5'h08;
         default: o_fifo_level_trigger = 5'h10;
      endcase
   end

   // ==========================================
   // Assertions
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   a_az_never_idle: // RULE1
   assert property ((i_cycle_start && st_reg.az_interval == `SGAC_AZ_NEVER)
                    |=> !o_autozero_start)
   else $error("auto-zero started with interval zero");

   a_az_every_cycle: // RULE1
   assert property ((i_cycle_start && st_reg.az_interval == 8'h01 && !tmr_busy)
                    |=> o_autozero_start)
   else $error("auto-zero missed with interval one");

   a_az_busy_hold: // RULE2
   assert property ($rose(o_autozero_busy) |-> o_autozero_busy [*8])
   else $error("auto-zero ended too early");

   a_az_adc5_flag: // RULE3
   assert property (o_autozero_start
                    |=> o_autozero_busy &&
                        o_autozero_adc5 == $past(i_flicker_detect_en, 2))
   else $error("converter 5 flag wrong at auto-zero");

   a_flicker_abort: // RULE4
   assert property (o_flicker_abort |-> o_autozero_start ##1 o_autozero_adc5)
   else $error("flicker abort without converter 5 auto-zero");

   a_ceil_limit: // RULE5
   assert property (o_gain_cfg.fd_ceil <= `SGAC_CEIL_MAX &&
                    o_gain_cfg.sp_ceil <= `SGAC_CEIL_MAX)
   else $error("gain ceiling above top code");

   a_fifo_irq_level: // RULE7
   assert property (({1'b0, o_fifo_level_trigger} <= i_fifo_count)
                    |=> o_fifo_irq)
   else $error("FIFO level reached without flag");

   a_agc_enable_wr: // RULE8
   assert property ((o_pready && i_pwrite && idx == `SGAC_IDX_CTRL)
                    |=> o_gain_cfg.flicker_auto_gain_en == $past(i_pwdata[`SGAC_FLICKER_AUTO_GAIN_EN_BIT]) &&
                        o_gain_cfg.spectral_auto_gain_en == $past(i_pwdata[`SGAC_SPECTRAL_AUTO_GAIN_EN_BIT]))
   else $error("gain enables not taken from write");

   a_part_read_only: // RULE10
   assert property ((acc && !st_reg.ack && !i_pwrite && idx == `SGAC_IDX_PART)
                    |=> o_prdata[7:0] == {PART_CODE, 2'h0})
   else $error("part number read back wrong");

   a_drop_thr_calc: // RULE12
   // Worked out from the inputs, not from the internal product
   assert property (1'b1 |=> o_gain_drop_threshold ==
                    25'((28'($past(i_full_scale)) *
                         (28'h000_0004 + 28'($past(i_gain_drop_level)))) >> 3))
   else $error("gain drop threshold wrong");

   a_pready_wait:
   assert property ((i_psel && !i_penable) |=> !o_pready)
   else $error("answer came in access phase first cycle");

endmodule // sgac_regs

// ===== sgac_host_model.sv
// APB host model that stands in for the register bus master
`timescale 1ns/100ps
module sgac_host_model (
   // Clock
   input  wire logic        i_clk,
   // APB request
   output logic             o_psel,
   output logic             o_penable,
   output logic             o_pwrite,
   output logic [11:0]      o_paddr,
   output logic [31:0]      o_pwdata,
   // APB answer
   input  wire logic [31:0] i_prdata,
   input  wire logic        i_pready,
   input  wire logic        i_pslverr
);
   // ==========================================
   // Idle bus at time zero
   initial begin
      o_psel    = 1'b0;
      o_penable = 1'b0;
      o_pwrite  = 1'b0;
      o_paddr   = 12'h000;
      o_pwdata  = 32'h0000_0000;
   end

   // ==========================================
   // One transfer: setup, then access until ready
   // Answer is taken at the rising edge where pready is seen high; no cycle
   // count is assumed, a lost answer is left to the bench watchdog.
   task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      rd  = 32'hxxxx_xxxx;
      err = 1'bx;
      @(posedge i_clk);
      o_psel    <= 1'b1;
      o_penable <= 1'b0;
      o_pwrite  <= wr;
      o_paddr   <= addr;
      o_pwdata  <= wd;
      @(posedge i_clk);
      o_penable <= 1'b1;
      // Request stands until the sampling edge sees ready
      @(posedge i_clk);
      while (i_pready !== 1'b1) begin
         @(posedge i_clk);
      end
      // Answer taken at that same edge, then the bus is released
      rd        = i_prdata;
      err       = i_pslverr;
      o_psel    <= 1'b0;
      o_penable <= 1'b0;
   endtask
endmodule // sgac_host_model

// ===== spectral_gain_autozero_config_bench.sv
// Self-checking testbench for the gain and auto-zero register bank
`timescale 1ns/100ps
`include "sgac_cfg.svh"
module spectral_gain_autozero_config_bench;
   // ==========================================
   // Settings and byte addresses
   localparam int          AZN    = 20;                      // Short auto-zero length
   localparam logic [11:0] A_AUX  = {`SGAC_IDX_AUX, 2'b00};  // Auxiliary code
   localparam logic [11:0] A_REV  = {`SGAC_IDX_REV, 2'b00};  // Revision
   localparam logic [11:0] A_PART = {`SGAC_IDX_PART, 2'b00}; // Part number
   localparam logic [11:0] A_CTRL = {`SGAC_IDX_CTRL, 2'b00}; // FIFO and gain control
   localparam logic [11:0] A_CEIL = {`SGAC_IDX_CEIL, 2'b00}; // Gain ceilings
   localparam logic [11:0] A_AZ   = {`SGAC_IDX_AZ, 2'b00};   // Auto-zero interval
   // ==========================================
   // Signals
   logic                     clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0]              paddr;
   logic [31:0]              pwdata, prdata, n_errors, comparisons;
   logic                     cyc, fen, frun, az_start, az_busy, az_adc5, fabort, firq;
   logic [5:0]               fcnt;
   logic [1:0]               lvl;
   logic [24:0]              fs, thr;
   logic [10:0]              sp_max, fd_max;
   logic [4:0]               trig;
   sgac_pkg::sgac_gain_cfg_t gcfg;

   // ==========================================
   // Design, with arbitrary identity values
   sgac_regs #(.AZ_CYCLES(AZN), .PART_CODE(6'h15), .REV_CODE(3'h3), .AUX_CODE(4'h6)) dut_u (
      .i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_cycle_start(cyc), .i_flicker_detect_en(fen),
      .i_flicker_running(frun), .i_fifo_count(fcnt), .i_gain_drop_level(lvl),
      .i_full_scale(fs), .o_autozero_start(az_start), .o_autozero_busy(az_busy),
      .o_autozero_adc5(az_adc5), .o_flicker_abort(fabort), .o_gain_cfg(gcfg),
      .o_spectral_gain_max(sp_max), .o_flicker_gain_max(fd_max),
      .o_gain_drop_threshold(thr), .o_fifo_level_trigger(trig), .o_fifo_irq(firq));
   // Register bus master
   sgac_host_model host_u (
      .i_clk(clk), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
      .o_pwdata(pwdata), .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr));

   // ==========================================
   // Shared tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      host_u.xfer(1'b1, a, d, r, e);
      // The write lands at the ready edge; let it settle before outputs are compared
      @(negedge clk);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      host_u.xfer(1'b0, a, 32'h0000_0000, r, e);
      check(r, exp);
      check({31'h0, e}, 32'h0000_0000);
   endtask
   // One integration start, then count what the auto-zero outputs do
   task automatic az_step(input logic [31:0] es, input logic [31:0] ea, input logic [31:0] ed);
      logic [31:0] ns, nb, na, nd;
      {ns, nb, na, nd} = '0;
      @(posedge clk) cyc <= 1'b1;
      @(posedge clk) cyc <= 1'b0;
      repeat (40) begin
         @(negedge clk);
         ns = ns + az_start;
         nb = nb + az_busy;
         na = na + fabort;
         nd = nd + az_adc5;
      end
      check(ns, es);
      check(nb, es * AZN);
      check(na, ea);
      check(nd, ed * AZN);
   endtask

   // ==========================================
   // Scenarios
   task automatic t_defaults;
      rd_chk(A_CTRL, 32'h0000_0088);
      rd_chk(A_CEIL, 32'h0000_0099);
      rd_chk(A_AZ, 32'h0000_00ff);
      check({22'h0, gcfg}, {22'h0, 4'h9, 4'h9, 2'b10});
      check({27'h0, trig}, 32'h0000_0008);
      check({21'h0, sp_max}, 32'h0000_0200);
   endtask
   task automatic t_ident;
      logic [31:0] r;
      logic        e;
      wr(A_AUX, 32'hffff_ffff);
      wr(A_REV, 32'hffff_ffff);
      wr(A_PART, 32'h0000_0000);
      rd_chk(A_AUX, 32'h0000_0006);
      rd_chk(A_REV, 32'h0000_0003);
      rd_chk(A_PART, 32'h0000_0054);
      host_u.xfer(1'b1, 12'h004, 32'h0000_00ff, r, e);
      check({31'h0, e}, 32'h0000_0001);
      host_u.xfer(1'b0, 12'h004, 32'h0000_0000, r, e);
      check(r, 32'h0000_0000);
   endtask
   task automatic t_ctrl;
      wr(A_CTRL, 32'hffff_ffff);
      rd_chk(A_CTRL, 32'h0000_00cc);
      check({30'h0, gcfg.flicker_auto_gain_en, gcfg.spectral_auto_gain_en}, 32'h0000_0003);
      wr(A_CTRL, 32'h0000_0000);
      check({30'h0, gcfg.flicker_auto_gain_en, gcfg.spectral_auto_gain_en}, 32'h0000_0000);
      wr(A_CEIL, 32'h0000_00a0);
      rd_chk(A_CEIL, 32'h0000_00a0);
      check({fd_max, sp_max}, {11'h400, 11'h001});
      wr(A_CEIL, 32'h0000_003b);
      rd_chk(A_CEIL, 32'h0000_003a);
      check({22'h0, gcfg.fd_ceil, gcfg.sp_ceil, 2'b00}, 32'h0000_00e8);
   endtask
   task automatic t_fifo;
      logic [4:0] lv [4] = '{5'd1, 5'd4, 5'd8, 5'd16};
      for (int c = 0; c < 4; c++) begin
         wr(A_CTRL, 32'(c) << 6);
         check({27'h0, trig}, {27'h0, lv[c]});
         @(posedge clk) fcnt <= {1'b0, lv[c]} - 6'd1;
         repeat (3) @(posedge clk);
         check({31'h0, firq}, 32'h0000_0000);
         fcnt <= {1'b0, lv[c]};
         repeat (3) @(posedge clk);
         check({31'h0, firq}, 32'h0000_0001);
      end
   endtask
   task automatic t_threshold;
      logic [31:0] exp;
      for (int c = 0; c < 4; c++) begin
         @(posedge clk) lvl <= 2'(c);
         fs <= 25'd1000;
         repeat (3) @(posedge clk);
         exp = (32'd1000 * (32'd4 + 32'(c))) >> 3;
         check({7'h0, thr}, exp);
      end
   endtask
   task automatic t_autozero;
      az_step(1, 0, 0);
      az_step(0, 0, 0);
      @(posedge clk) fen <= 1'b1;
      frun <= 1'b1;
      wr(A_AZ, 32'h0000_0002);
      az_step(1, 1, 1);
      az_step(0, 0, 0);
      az_step(1, 1, 1);
      @(posedge clk) frun <= 1'b0;
      wr(A_AZ, 32'h0000_0001);
      az_step(1, 0, 1);
      @(posedge clk) fen <= 1'b0;
      az_step(1, 0, 0);
      wr(A_AZ, 32'h0000_0000);
      az_step(0, 0, 0);
   endtask

   // ==========================================
   // Verdict and end of run
   task automatic summarize;
      if (n_errors == 0 && comparisons != 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ==========================================
   // Clock, watchdog and main sequence
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #400000;
      n_errors = n_errors + 1;
      summarize();
   end
   initial begin
      {n_errors, comparisons} = '0;
      {rst_n, cyc, fen, frun, fcnt, lvl, fs} = '0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_defaults();
      t_ident();
      t_ctrl();
      t_fifo();
      t_threshold();
      t_autozero();
      summarize();
   end
endmodule // spectral_gain_autozero_config_bench
